// file: mpc_pkg.sv
// Constants and types shared by the Manchester preamble codec files
// Function
// R1 - Configuration writes are dropped while write protection is enabled.
// R2 - Transmit preamble length zero sends no preamble before the frame.
// R3 - Transmit preamble length one to fifteen lasts that many bit periods.
// R4 - Transmit pattern code selects ones, zeros, zero-one pairs or one-zero pairs.
// R5 - Transmit polarity zero: zero rises mid-bit, one falls mid-bit.
// R6 - Transmit polarity one: zero falls mid-bit, one rises mid-bit.
// R7 - Receive preamble length zero disables preamble detection.
// R8 - Receive preamble length one to fifteen expects that many bit periods.
// R9 - Receive pattern code selects the expected preamble like the transmit code.
// R10 - Receive polarity inverts decoding; the expected preamble follows that polarity.
// R11 - Both link ends must share polarity and preamble settings.
package mpc_pkg;

	// ---------------------------------------------------------------
	// Register addresses
	// ---------------------------------------------------------------
	localparam logic [31:0] CFG_ADDR   = 32'hf8034250;
	localparam logic [31:0] STAT_ADDR  = 32'hf8034254;
	localparam logic [31:0] TXD_ADDR   = 32'hf8034258;
	localparam logic [31:0] RXD_ADDR   = 32'hf803425c;
	localparam logic [31:0] WPROT_ADDR = 32'hf80342e4;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int TX_LEN_LSB = 0;
	localparam int TX_PAT_LSB = 8;
	localparam int TX_POL_BIT = 12;
	localparam int RX_LEN_LSB = 16;
	localparam int RX_PAT_LSB = 24;
	localparam int RX_POL_BIT = 28;
	localparam int PROT_BIT   = 0;
	localparam int ST_RX_READY = 0;
	localparam int ST_RX_OVR   = 1;
	localparam int ST_TX_FULL  = 2;
	localparam int ST_TX_EMPTY = 3;
	localparam int ST_TX_BUSY  = 4;
	localparam int ST_RX_LOCK  = 5;
	localparam int ST_TX_OVF   = 6;
	localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
	localparam logic [31:0] CFG_MASK    = 32'h130f_130f;
	localparam logic        PROT_RESET  = 1'b0;
	localparam logic        IDLE_LEVEL  = 1'b0;
	localparam logic [3:0]  PL_OFF      = 4'h0;

	// ---------------------------------------------------------------
	// Preamble pattern codes
	// ---------------------------------------------------------------
	localparam logic [1:0] PP_ALL_ONE  = 2'h0;
	localparam logic [1:0] PP_ALL_ZERO = 2'h1;
	localparam logic [1:0] PP_ZERO_ONE = 2'h2;
	localparam logic [1:0] PP_ONE_ZERO = 2'h3;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_FREQ_MHZ  = 200;
	localparam int BIT_PERIOD_NS = 100;
	localparam int BIT_CYC       = (BIT_PERIOD_NS * CLK_FREQ_MHZ) / 1000;
	localparam int HALF_CYC      = BIT_CYC / 2;
	localparam int CNT_W         = 6;
	localparam logic [CNT_W-1:0] BIT_LAST   = CNT_W'(BIT_CYC - 1);
	localparam logic [CNT_W-1:0] HALF_CNT   = CNT_W'(HALF_CYC);
	localparam logic [CNT_W-1:0] RX_MID_MIN = CNT_W'((3 * HALF_CYC) / 2);
	localparam logic [CNT_W-1:0] RX_LOSS    = CNT_W'(3 * HALF_CYC);

	// ---------------------------------------------------------------
	// Data path and state types
	// ---------------------------------------------------------------
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [2:0] BYTE_LAST = 3'h7;

	typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA} mpc_tx_state_type;
	typedef enum logic [1:0] {RX_HUNT, RX_PRE, RX_DATA} mpc_rx_state_type;

endpackage

// file: mpc_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module mpc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock, reset and enable
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic             ce,
	// Fill side
	input  wire logic             in_valid,
	output wire logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output wire logic             out_valid,
	input  wire logic             out_ready,
	output wire logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;

	wire push = ce & in_valid & in_ready;
	wire pop  = ce & out_valid & out_ready;

	assign in_ready  = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data  = mem_q[rd_ptr_q];

	// Storage needs no reset; only pointers and count define content
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
			end
			if (push && !pop) begin
				count_q <= count_q + (AW+1)'(1);
			end else if (pop && !push) begin
				count_q <= count_q - (AW+1)'(1);
			end
		end
	end

endmodule

// file: mpc_codec.sv
// Manchester codec with programmable preamble, polarity and register port
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module mpc_codec (
	// Clock, reset and enable
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// Register port
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Serial link
	output logic             tx_line,
	input  wire logic        rx_line
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [31:0]                    cfg_q;
	logic                           write_protect_enable_q;
	logic [31:0]                    rdata_d;
	logic                           rx_ready_q;
	logic                           rx_ovr_q;
	logic                           tx_ovf_q;
	logic [mpc_pkg::DATA_W-1:0]     rx_byte_q;
	mpc_pkg::mpc_tx_state_type      tx_state_q;
	logic [mpc_pkg::CNT_W-1:0]      tx_cnt_q;
	logic [3:0]                     tx_idx_q;
	logic [mpc_pkg::DATA_W-1:0]     tx_shift_q;
	logic                           tx_line_d;
	logic                           rx_s1_q;
	logic                           rx_s2_q;
	logic                           rx_prev_q;
	logic                           rx_frame_q;
	logic [mpc_pkg::CNT_W-1:0]      rx_cnt_q;
	mpc_pkg::mpc_rx_state_type      rx_state_q;
	logic [3:0]                     rx_idx_q;
	logic [mpc_pkg::DATA_W-1:0]     rx_shift_q;
	logic                           fifo_in_ready;
	logic                           fifo_out_valid;
	logic [mpc_pkg::DATA_W-1:0]     fifo_out_data;

	// ---------------------------------------------------------------
	// Preamble bit for a pattern code and bit parity
	// ---------------------------------------------------------------
	// R11 - one encoding both ends
	function automatic logic pattern_bit(input logic [1:0] pp, input logic odd);
		logic b;
		b = 1'b1;
		case (pp)
			mpc_pkg::PP_ALL_ONE:  b = 1'b1;
			mpc_pkg::PP_ALL_ZERO: b = 1'b0;
			mpc_pkg::PP_ZERO_ONE: b = odd;
			default:              b = ~odd;
		endcase
		return b;
	endfunction

	// ---------------------------------------------------------------
	// Configuration fields
	// ---------------------------------------------------------------
	wire [3:0] tx_preamble_length  = cfg_q[mpc_pkg::TX_LEN_LSB +: 4];
	wire [1:0] tx_preamble_pattern = cfg_q[mpc_pkg::TX_PAT_LSB +: 2];
	wire       tx_coding_polarity  = cfg_q[mpc_pkg::TX_POL_BIT];
	wire [3:0] rx_preamble_length  = cfg_q[mpc_pkg::RX_LEN_LSB +: 4];
	wire [1:0] rx_preamble_pattern = cfg_q[mpc_pkg::RX_PAT_LSB +: 2];
	wire       rx_coding_polarity  = cfg_q[mpc_pkg::RX_POL_BIT];

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire hit_cfg   = (reg_addr == mpc_pkg::CFG_ADDR);
	wire hit_stat  = (reg_addr == mpc_pkg::STAT_ADDR);
	wire hit_txd   = (reg_addr == mpc_pkg::TXD_ADDR);
	wire hit_rxd   = (reg_addr == mpc_pkg::RXD_ADDR);
	wire hit_wprot = (reg_addr == mpc_pkg::WPROT_ADDR);

	// R1 - protected config write
	wire cfg_we    = reg_wr & hit_cfg & ~write_protect_enable_q;
	wire wprot_we  = reg_wr & hit_wprot;
	wire txd_we    = reg_wr & hit_txd;
	wire stat_we   = reg_wr & hit_stat;
	wire rxd_rd    = reg_rd & hit_rxd;

	// ---------------------------------------------------------------
	// Status word
	// ---------------------------------------------------------------
	wire tx_busy = (tx_state_q != mpc_pkg::TX_IDLE);
	wire rx_lock = (rx_state_q == mpc_pkg::RX_DATA);
	wire [31:0] status_word = {25'h0, tx_ovf_q, rx_lock, tx_busy,
		~fifo_out_valid, ~fifo_in_ready, rx_ovr_q, rx_ready_q};

	// Unmapped reads answer zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (!reg_rd) begin
			rdata_d = 32'h0000_0000;
		end else if (hit_cfg) begin
			rdata_d = cfg_q;
		end else if (hit_stat) begin
			rdata_d = status_word;
		end else if (hit_rxd) begin
			rdata_d = {24'h0, rx_byte_q};
		end else if (hit_wprot) begin
			rdata_d = {31'h0, write_protect_enable_q};
		end
	end

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg_q     <= mpc_pkg::CFG_RESET;
			write_protect_enable_q <= mpc_pkg::PROT_RESET;
			reg_rdata <= 32'h0000_0000;
		end else if (ce) begin
			reg_rdata <= rdata_d;
			if (cfg_we) begin
				cfg_q <= reg_wdata & mpc_pkg::CFG_MASK;
			end
			if (wprot_we) begin
				write_protect_enable_q <= reg_wdata[mpc_pkg::PROT_BIT];
			end
		end
	end

	// ---------------------------------------------------------------
	// Transmit buffer
	// ---------------------------------------------------------------
	wire tx_push_drop = txd_we & ~fifo_in_ready;
	wire tx_take;

	mpc_fifo #(
		.WIDTH (mpc_pkg::DATA_W),
		.DEPTH (mpc_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.mclk      (mclk),
		.rstn      (rstn),
		.ce        (ce),
		.in_valid  (txd_we),
		.in_ready  (fifo_in_ready),
		.in_data   (reg_wdata[mpc_pkg::DATA_W-1:0]),
		.out_valid (fifo_out_valid),
		.out_ready (tx_take),
		.out_data  (fifo_out_data)
	);

	// ---------------------------------------------------------------
	// Transmit encoder
	// ---------------------------------------------------------------
	wire tx_bit_end  = (tx_cnt_q == mpc_pkg::BIT_LAST);
	wire tx_first    = (tx_cnt_q < mpc_pkg::HALF_CNT);
	wire tx_byte_end = tx_bit_end & (tx_idx_q[2:0] == mpc_pkg::BYTE_LAST);
	// R4 - preamble content by code
	wire tx_pre_bit  = pattern_bit(tx_preamble_pattern, tx_idx_q[0]);
	wire tx_cur_bit  = (tx_state_q == mpc_pkg::TX_PRE) ? tx_pre_bit
		: tx_shift_q[mpc_pkg::DATA_W-1];
	// R5 - first half equals the bit when polarity is zero
	// R6 - polarity one swaps both halves
	wire tx_half1    = tx_cur_bit ^ tx_coding_polarity;
	wire tx_pre_done = tx_bit_end & ({1'b0, tx_idx_q} + 5'h1 >= {1'b0, tx_preamble_length});

	// Next byte joins the frame without a gap or a new preamble
	assign tx_take = ((tx_state_q == mpc_pkg::TX_IDLE) | (tx_state_q == mpc_pkg::TX_DATA
		& tx_byte_end)) & fifo_out_valid;

	always_comb begin
		tx_line_d = mpc_pkg::IDLE_LEVEL;
		if (tx_busy) begin
			tx_line_d = tx_first ? tx_half1 : ~tx_half1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_state_q <= mpc_pkg::TX_IDLE;
			tx_cnt_q   <= '0;
			tx_idx_q   <= 4'h0;
			tx_shift_q <= '0;
			tx_line    <= mpc_pkg::IDLE_LEVEL;
		end else if (ce) begin
			tx_line  <= tx_line_d;
			tx_cnt_q <= (tx_bit_end || !tx_busy) ? '0 : tx_cnt_q + mpc_pkg::CNT_W'(1);
			case (tx_state_q)
				mpc_pkg::TX_IDLE: begin
					tx_idx_q <= 4'h0;
					if (fifo_out_valid) begin
						tx_shift_q <= fifo_out_data;
						// R2 - zero length skips the preamble
						tx_state_q <= (tx_preamble_length == mpc_pkg::PL_OFF)
							? mpc_pkg::TX_DATA : mpc_pkg::TX_PRE;
					end
				end
				mpc_pkg::TX_PRE: begin
					// R3 - preamble lasts length bit periods
					if (tx_pre_done) begin
						tx_idx_q   <= 4'h0;
						tx_state_q <= mpc_pkg::TX_DATA;
					end else if (tx_bit_end) begin
						tx_idx_q <= tx_idx_q + 4'h1;
					end
				end
				mpc_pkg::TX_DATA: begin
					if (tx_byte_end) begin
						tx_idx_q <= 4'h0;
						if (fifo_out_valid) begin
							tx_shift_q <= fifo_out_data;
						end else begin
							tx_state_q <= mpc_pkg::TX_IDLE;
						end
					end else if (tx_bit_end) begin
						tx_idx_q   <= tx_idx_q + 4'h1;
						tx_shift_q <= {tx_shift_q[mpc_pkg::DATA_W-2:0], 1'b0};
					end
				end
				default: tx_state_q <= mpc_pkg::TX_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Receive synchroniser and bit recovery
	// ---------------------------------------------------------------
	wire rx_edge    = rx_s2_q ^ rx_prev_q;
	// Edges early in the bit are cell boundaries, not data
	wire rx_mid     = rx_frame_q & rx_edge & (rx_cnt_q >= mpc_pkg::RX_MID_MIN);
	wire rx_lost    = rx_frame_q & ~rx_edge & (rx_cnt_q >= mpc_pkg::RX_LOSS);
	// R10 - inverse of the level after the mid-bit edge, polarity applied
	wire rx_bit     = ~rx_s2_q ^ rx_coding_polarity;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_s1_q    <= mpc_pkg::IDLE_LEVEL;
			rx_s2_q    <= mpc_pkg::IDLE_LEVEL;
			rx_prev_q  <= mpc_pkg::IDLE_LEVEL;
			rx_frame_q <= 1'b0;
			rx_cnt_q   <= '0;
		end else if (ce) begin
			rx_s1_q   <= rx_line;
			rx_s2_q   <= rx_s1_q;
			rx_prev_q <= rx_s2_q;
			if (!rx_frame_q) begin
				// First edge is taken as a cell boundary
				if (rx_edge) begin
					rx_frame_q <= 1'b1;
					rx_cnt_q   <= mpc_pkg::HALF_CNT;
				end
			end else if (rx_lost) begin
				rx_frame_q <= 1'b0;
			end else if (rx_mid) begin
				rx_cnt_q <= '0;
			end else begin
				rx_cnt_q <= rx_cnt_q + mpc_pkg::CNT_W'(1);
			end
		end
	end

	// ---------------------------------------------------------------
	// Receive preamble detection and byte assembly
	// ---------------------------------------------------------------
	// R9 - expected preamble bit by code
	wire rx_exp      = pattern_bit(rx_preamble_pattern, rx_idx_q[0]);
	wire rx_exp0     = pattern_bit(rx_preamble_pattern, 1'b0);
	wire rx_pre_done = ({1'b0, rx_idx_q} + 5'h1 >= {1'b0, rx_preamble_length});
	wire rx_byte_end = rx_mid & (rx_state_q == mpc_pkg::RX_DATA)
		& (rx_idx_q[2:0] == mpc_pkg::BYTE_LAST);
	wire [mpc_pkg::DATA_W-1:0] rx_byte_d = {rx_shift_q[mpc_pkg::DATA_W-2:0], rx_bit};

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_state_q <= mpc_pkg::RX_HUNT;
			rx_idx_q   <= 4'h0;
			rx_shift_q <= '0;
			rx_byte_q  <= '0;
		end else if (ce) begin
			if (rx_lost) begin
				rx_state_q <= mpc_pkg::RX_HUNT;
				rx_idx_q   <= 4'h0;
			end else begin
				case (rx_state_q)
					mpc_pkg::RX_HUNT: begin
						rx_idx_q <= 4'h0;
						// R7 - no detection at zero length
						// Length checked at frame start; settings are not held, so changes apply at once
						if (rx_frame_q) begin
							rx_state_q <= (rx_preamble_length == mpc_pkg::PL_OFF)
								? mpc_pkg::RX_DATA : mpc_pkg::RX_PRE;
						end
					end
					mpc_pkg::RX_PRE: begin
						// R8 - length matching bits complete the preamble
						if (rx_mid && rx_bit == rx_exp && rx_pre_done) begin
							rx_idx_q   <= 4'h0;
							rx_state_q <= mpc_pkg::RX_DATA;
						end else if (rx_mid && rx_bit == rx_exp) begin
							rx_idx_q <= rx_idx_q + 4'h1;
						end else if (rx_mid) begin
							// Mismatch may itself start a new preamble
							rx_idx_q <= (rx_bit == rx_exp0) ? 4'h1 : 4'h0;
						end
					end
					mpc_pkg::RX_DATA: begin
						if (rx_byte_end) begin
							rx_idx_q  <= 4'h0;
							rx_byte_q <= rx_byte_d;
						end else if (rx_mid) begin
							rx_idx_q   <= rx_idx_q + 4'h1;
							rx_shift_q <= rx_byte_d;
						end
					end
					default: rx_state_q <= mpc_pkg::RX_HUNT;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Sticky status flags, set wins over clear
	// ---------------------------------------------------------------
	wire ovr_clr = stat_we & reg_wdata[mpc_pkg::ST_RX_OVR];
	wire ovf_clr = stat_we & reg_wdata[mpc_pkg::ST_TX_OVF];
	wire ovr_set = rx_byte_end & rx_ready_q & ~rxd_rd;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_ready_q <= 1'b0;
			rx_ovr_q   <= 1'b0;
			tx_ovf_q   <= 1'b0;
		end else if (ce) begin
			rx_ready_q <= rx_byte_end | (rx_ready_q & ~rxd_rd);
			rx_ovr_q   <= ovr_set | (rx_ovr_q & ~ovr_clr);
			tx_ovf_q   <= tx_push_drop | (tx_ovf_q & ~ovf_clr);
		end
	end

endmodule

// file: mpc_codec_monitor.sv
// Port-level assertions for the Manchester preamble codec
`timescale 1ns/1ps
module mpc_codec_monitor (
	// Clock, reset and enable
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        ce,
	// Register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Serial link
	input wire logic        tx_line,
	input wire logic        rx_line
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic [31:0] cfg_q;
	logic        wp_q;
	logic        tx_q;
	logic [5:0]  run_q;
	wire         cfg_wr = ce && reg_wr && reg_addr == mpc_pkg::CFG_ADDR;
	wire         cfg_rd = ce && reg_rd && reg_addr == mpc_pkg::CFG_ADDR;
	wire         wp_rd  = ce && reg_rd && reg_addr == mpc_pkg::WPROT_ADDR;
	wire         tx_wr  = ce && reg_wr && reg_addr == mpc_pkg::TXD_ADDR;
	wire         chg    = tx_line != tx_q;
	wire         mapped = reg_addr inside {mpc_pkg::CFG_ADDR, mpc_pkg::STAT_ADDR,
		mpc_pkg::TXD_ADDR, mpc_pkg::RXD_ADDR, mpc_pkg::WPROT_ADDR};
	// First half cell: preamble bit 0, or data MSB without preamble
	wire         first_b = (cfg_q[3:0] != 4'h0 ? (cfg_q[9:8] == 2'h0 || cfg_q[9:8] == 2'h3)
		: reg_wdata[7]) ^ cfg_q[12];

	// ---------------------------------------------------------------
	// Shadow state
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= mpc_pkg::CFG_RESET;
			wp_q  <= mpc_pkg::PROT_RESET;
			tx_q  <= 1'b0;
			run_q <= 6'h3f;
		end else begin
			if (cfg_wr && !wp_q) begin
				cfg_q <= reg_wdata & mpc_pkg::CFG_MASK;
			end
			if (ce && reg_wr && reg_addr == mpc_pkg::WPROT_ADDR) begin
				wp_q <= reg_wdata[0];
			end
			tx_q  <= tx_line;
			run_q <= chg ? 6'h0 : (run_q == 6'h3f ? run_q : run_q + 6'h1);
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_cfg_readback: assert property (cfg_rd |=> reg_rdata == cfg_q)
		else $error("configuration read back wrong");
	a_wprot_read: assert property (wp_rd |=> reg_rdata[0] == wp_q)
		else $error("protection bit read back wrong");
	a_rdata_quiet: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (ce && reg_rd && !mapped |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_tx_first_level: assert property (tx_wr && run_q == 6'h3f && !tx_line
		&& !$past(reg_wr) |-> ##3 tx_line == $past(first_b, 3))
		else $error("first half cell level wrong");
	a_half_hold: assert property (chg |=> !chg [*8])
		else $error("half cell too short");
	a_cell_length: assert property (chg && run_q < 6'h28 |-> run_q == 6'h9 || run_q == 6'h13)
		else $error("transition off the half cell grid");
	a_reset_idle: assert property ($rose(rstn) |-> !tx_line)
		else $error("line not idle after reset");
	c_locked_write: cover property (cfg_wr && wp_q);
	c_tx_start: cover property (tx_wr && run_q == 6'h3f);
	c_full_cell: cover property (chg && run_q == 6'h13);
endmodule

// file: mpc_remote.sv
// Behavioural far-end Manchester transmitter feeding the receive pin
`timescale 1ns/1ps
module mpc_remote (
	// Clock
	input wire logic       mclk,
	// Frame request and settings
	input wire logic       send,
	input wire logic [7:0] data,
	input wire logic [3:0] pl,
	input wire logic [1:0] pp,
	input wire logic       pol,
	input wire logic       slow,
	output logic           busy,
	// Line toward the codec
	output logic           rx_line
);
	logic lvl;
	int   h;
	initial begin
		rx_line = 1'b0;
		busy    = 1'b0;
		forever begin
			@(posedge mclk);
			if (send) begin
				busy <= 1'b1;
				// Slow mode stretches each half cell, still inside lock range
				h = slow ? 11 : 10;
				for (int i = 0; i < pl + 8; i++) begin
					lvl = i < pl ? (pp == 2'h0 || (pp[1] && (pp[0] ^ i[0]))) : data[7 - (i - pl)];
					// polarity picks the first half level
					rx_line <= lvl ^ pol;
					repeat (h) @(posedge mclk);
					rx_line <= ~(lvl ^ pol);
					repeat (h) @(posedge mclk);
				end
				// Released line falls to its pull-down level
				rx_line <= 1'b0;
				busy    <= 1'b0;
			end
		end
	end
endmodule

// file: test_manchester_preamble_codec_config.sv
// Self-checking testbench for the Manchester preamble codec
`timescale 1ns/1ps
module test_manchester_preamble_codec_config;
	logic        mclk;
	logic        rstn;
	logic        ce;
	logic [31:0] reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	wire  [31:0] reg_rdata;
	wire         tx_line;
	wire         rx_line;
	logic        p_send;
	logic [7:0]  p_data;
	logic [3:0]  p_pl;
	logic [1:0]  p_pp;
	logic        p_pol;
	logic        p_slow;
	wire         p_busy;
	int          bad_count = 0;
	int          total_checks = 0;
	int          cyc = 0;

	mpc_codec mpc_codec_i (.mclk(mclk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tx_line(tx_line), .rx_line(rx_line));
	mpc_remote mpc_remote_i (.mclk(mclk), .send(p_send), .data(p_data), .pl(p_pl), .pp(p_pp),
		.pol(p_pol), .slow(p_slow), .busy(p_busy), .rx_line(rx_line));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			stop_test();
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_line(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t line %b expected %b", $time, got, exp);
		end
	endtask
	// Strobe stays up; caller ends a burst with idle or rd
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b0;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
	endtask
	task automatic idle;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		reg_wr   <= 1'b0;
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		// Read data stand only until the next edge
		@(negedge mclk);
		d = reg_rdata;
		@(posedge mclk);
	endtask
	function automatic logic [31:0] mk(input logic [3:0] tpl, input logic [1:0] tpp,
		input logic tpol, input logic [3:0] rpl, input logic [1:0] rpp, input logic rpol);
		return {3'h0, rpol, 2'h0, rpp, 4'h0, rpl, 3'h0, tpol, 2'h0, tpp, 4'h0, tpl};
	endfunction
	function automatic logic pat(input logic [1:0] c, input int i);
		return c == 2'h0 || (c[1] && (c[0] ^ i[0]));
	endfunction

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic test_regs;
		logic [31:0] d;
		rd(mpc_pkg::CFG_ADDR, d);
		chk_word(d, mpc_pkg::CFG_RESET);
		wr(mpc_pkg::CFG_ADDR, 32'hffff_ffff);
		rd(mpc_pkg::CFG_ADDR, d);
		chk_word(d, mpc_pkg::CFG_MASK);
		wr(mpc_pkg::WPROT_ADDR, 32'h1);
		wr(mpc_pkg::CFG_ADDR, 32'h0);
		rd(mpc_pkg::CFG_ADDR, d);
		chk_word(d, mpc_pkg::CFG_MASK);
		rd(32'hf8034300, d);
		chk_word(d, 32'h0);
		wr(mpc_pkg::WPROT_ADDR, 32'h0);
		wr(mpc_pkg::CFG_ADDR, 32'h0000_0105);
		ce <= 1'b0;
		wr(mpc_pkg::CFG_ADDR, 32'h0);
		ce <= 1'b1;
		rd(mpc_pkg::CFG_ADDR, d);
		chk_word(d, 32'h0000_0105);
		$display("registers done");
	endtask
	task automatic test_tx(input logic [3:0] pl, input logic [1:0] pp, input logic pol,
		input logic [7:0] data);
		logic b;
		wr(mpc_pkg::CFG_ADDR, mk(pl, pp, pol, 4'h0, 2'h0, 1'b0));
		idle();
		wr(mpc_pkg::TXD_ADDR, {24'h0, data});
		idle();
		@(posedge mclk);
		repeat (5) @(negedge mclk);
		for (int i = 0; i < pl + 8; i++) begin
			b = i < pl ? pat(pp, i) : data[7 - (i - pl)];
			chk_line(tx_line, b ^ pol);
			repeat (10) @(negedge mclk);
			chk_line(tx_line, ~(b ^ pol));
			repeat (10) @(negedge mclk);
		end
		chk_line(tx_line, 1'b0);
		repeat (70) @(posedge mclk);
		$display("transmit done");
	endtask
	task automatic test_rx(input logic [3:0] pl, input logic [1:0] pp, input logic pol,
		input logic [7:0] data, input logic [1:0] rpp, input logic ok, input logic slow);
		logic [31:0] d;
		wr(mpc_pkg::CFG_ADDR, mk(4'h0, 2'h0, pol, pl, rpp, pol));
		idle();
		p_pl   <= pl;
		p_pp   <= pp;
		p_pol  <= pol;
		p_data <= data;
		p_slow <= slow;
		p_send <= 1'b1;
		@(posedge mclk);
		p_send <= 1'b0;
		repeat (2) @(posedge mclk);
		for (int k = 0; k < 2000 && p_busy; k++) @(posedge mclk);
		repeat (40) @(posedge mclk);
		rd(mpc_pkg::STAT_ADDR, d);
		chk_word({31'h0, d[0]}, {31'h0, ok});
		if (ok) begin
			rd(mpc_pkg::RXD_ADDR, d);
			chk_word(d & 32'hff, {24'h0, data});
			rd(mpc_pkg::STAT_ADDR, d);
			chk_word({31'h0, d[0]}, 32'h0);
		end
		$display("receive done");
	endtask
	task automatic test_fifo;
		logic [31:0] d;
		wr(mpc_pkg::CFG_ADDR, mk(4'h0, 2'h0, 1'b0, 4'h0, 2'h0, 1'b0));
		idle();
		for (int k = 0; k < 40; k++) wr(mpc_pkg::TXD_ADDR, 32'h80 + k);
		idle();
		rd(mpc_pkg::STAT_ADDR, d);
		chk_word(d & 32'h44, 32'h44);
		for (int k = 0; k < 5000 && !(d[3] && !d[4]); k++) rd(mpc_pkg::STAT_ADDR, d);
		chk_word(d & 32'h1c, 32'h08);
		wr(mpc_pkg::STAT_ADDR, 32'h40);
		rd(mpc_pkg::STAT_ADDR, d);
		chk_word(d & 32'h40, 32'h0);
		$display("buffer done");
	endtask

	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		p_send = 1'b0;
		p_data = 8'h0;
		p_pl = 4'h0;
		p_pp = 2'h0;
		p_pol = 1'b0;
		p_slow = 1'b0;
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		test_regs();
		test_tx(4'h0, 2'h0, 1'b0, 8'h80);
		test_tx(4'h1, 2'h0, 1'b0, 8'h80);
		test_tx(4'h3, 2'h1, 1'b0, 8'ha5);
		test_tx(4'h4, 2'h2, 1'b1, 8'h3c);
		test_tx(4'hf, 2'h3, 1'b1, 8'hc3);
		test_rx(4'h0, 2'h0, 1'b0, 8'h80, 2'h0, 1'b1, 1'b0);
		test_rx(4'h4, 2'h0, 1'b0, 8'h5a, 2'h0, 1'b1, 1'b1);
		test_rx(4'h3, 2'h3, 1'b0, 8'hc3, 2'h3, 1'b1, 1'b0);
		test_rx(4'h2, 2'h1, 1'b1, 8'h0f, 2'h1, 1'b1, 1'b0);
		test_rx(4'h5, 2'h2, 1'b1, 8'h96, 2'h2, 1'b1, 1'b0);
		test_rx(4'h4, 2'h1, 1'b1, 8'h00, 2'h0, 1'b0, 1'b0);
		test_fifo();
		stop_test();
	end
endmodule

bind mpc_codec mpc_codec_monitor mpc_codec_monitor_i (.mclk(mclk), .rstn(rstn), .ce(ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tx_line(tx_line), .rx_line(rx_line));
